// ---- lock_clear_host.v ----
// Purpose: host sequencer for clearing all block lock bits and configuring status pin
// Assumes: flash pins synchronous to core_clk_in; device does the gating itself
// Notes: reports device status byte and its error bits to the user
`timescale 1ns/1ps
`include "lockcfg_consts.vh"

module lock_clear_host
(
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    input  wire        clear_req_in,
    input  wire        config_req_in,
    input  wire [1:0]  pin_mode_code_bits_in,
    input  wire        status_output_pin_in,
    input  wire [7:0]  flash_dq_in,
    output wire [7:0]  flash_dq_out,
    output wire        flash_dq_oe_out,
    output wire        flash_we_n_out,
    output wire        flash_oe_n_out,
    output wire        busy_out,
    output reg         done_out,
    output reg  [7:0]  status_out,
    output reg         clear_fail_out,
    output reg         protection_error_out,
    output reg         low_voltage_out,
    output reg         sequence_error_out,
    output reg         config_rejected_out,
    output reg         retry_needed_out
);

    localparam [3:0] S_IDLE      = 4'h0;
    localparam [3:0] S_PRE_POLL  = 4'h1;
    localparam [3:0] S_PRE_WAIT  = 4'h2;
    localparam [3:0] S_SETUP     = 4'h3;
    localparam [3:0] S_CONFIRM   = 4'h4;
    localparam [3:0] S_POLL      = 4'h5;
    localparam [3:0] S_POLL_WAIT = 4'h6;
    localparam [3:0] S_CLR_STAT  = 4'h7;
    localparam [3:0] S_FINISH    = 4'h8;
    localparam [3:0] S_RD_STAT   = 4'h9;

    reg  [3:0]   state_r;
    reg          op_config_r;
    reg  [1:0]   code_r;
    reg          issued_r;
    reg  [15:0]  poll_cnt_r;
    reg          bus_start;
    reg          bus_write;
    reg  [7:0]   bus_wdata;
    wire [7:0]   bus_rdata;
    wire         bus_done;
    wire         st_ready;
    wire         st_err;

    bus_cycle_engine u_bus
    (
        .core_clk_in     (core_clk_in),
        .rst_n_in        (rst_n_in),
        .start_in        (bus_start),
        .write_in        (bus_write),
        .wdata_in        (bus_wdata),
        .flash_dq_in     (flash_dq_in),
        .flash_dq_out    (flash_dq_out),
        .flash_dq_oe_out (flash_dq_oe_out),
        .flash_we_n_out  (flash_we_n_out),
        .flash_oe_n_out  (flash_oe_n_out),
        .rdata_out       (bus_rdata),
        .done_out        (bus_done)
    );

    assign busy_out = (state_r != S_IDLE);
    assign st_ready = bus_rdata[`SR_READY];
    assign st_err   = bus_rdata[`SR_ERASE_ERR] | bus_rdata[`SR_PROG_ERR];

    // ========================================
    // bus request per state
    always @*
    begin
        bus_start = 1'b0;
        bus_write = 1'b0;
        bus_wdata = 8'h00;
        if (!issued_r)
        begin
            case (state_r)
                S_PRE_POLL, S_POLL:
                    bus_start = 1'b1;
                S_SETUP:
                begin
                    bus_start = 1'b1;
                    bus_write = 1'b1;
                    bus_wdata = op_config_r ? `CMD_PIN_CONFIG : `CMD_CLEAR_SETUP; // RQ4 RQ21
                end
                S_CONFIRM:
                begin
                    bus_start = 1'b1;
                    bus_write = 1'b1;
                    // upper six code bits always written as zero
                    bus_wdata = op_config_r ? ({6'h00, code_r} & `CODE_MASK)
                                            : `CMD_CLEAR_CONFIRM; // RQ18 RQ21 RQ4
                end
                S_CLR_STAT:
                begin
                    bus_start = 1'b1;
                    bus_write = 1'b1;
                    bus_wdata = `CMD_CLEAR_STATUS; // RQ7
                end
                S_RD_STAT:
                begin
                    bus_start = 1'b1;
                    bus_write = 1'b1;
                    bus_wdata = `CMD_READ_STATUS; // RQ25
                end
                default:
                    bus_start = 1'b0;
            endcase
        end
    end

    // ========================================
    // command sequencer
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r              <= S_IDLE;
            op_config_r          <= 1'b0;
            code_r               <= `CODE_LEVEL;
            issued_r             <= 1'b0;
            poll_cnt_r           <= 16'h0000;
            done_out             <= 1'b0;
            status_out           <= 8'h00;
            clear_fail_out       <= 1'b0;
            protection_error_out <= 1'b0;
            low_voltage_out      <= 1'b0;
            sequence_error_out   <= 1'b0;
            config_rejected_out  <= 1'b0;
            retry_needed_out     <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            if (bus_start)
                issued_r <= 1'b1;
            if (bus_done)
                issued_r <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    poll_cnt_r <= 16'h0000;
                    if (clear_req_in || config_req_in)
                    begin
                        op_config_r <= ~clear_req_in;
                        code_r <= pin_mode_code_bits_in;
                        clear_fail_out <= 1'b0;
                        protection_error_out <= 1'b0;
                        low_voltage_out <= 1'b0;
                        sequence_error_out <= 1'b0;
                        config_rejected_out <= 1'b0;
                        retry_needed_out <= 1'b0;
                        // device must be idle first; status reads need a ready check
                        state_r <= S_RD_STAT; // RQ3 RQ25
                    end
                end
                S_RD_STAT:
                    if (bus_done)
                        state_r <= S_PRE_POLL;
                S_PRE_POLL:
                    if (bus_done)
                        state_r <= S_PRE_WAIT;
                S_PRE_WAIT:
                begin
                    // read-status written first, so array data never passes as idle
                    if (st_ready && !bus_rdata[`SR_SUSPEND])
                        state_r <= S_SETUP; // RQ25 RQ3
                    else if (poll_cnt_r == `POLL_LIMIT)
                    begin
                        retry_needed_out <= 1'b1;
                        state_r <= S_FINISH;
                    end
                    else
                    begin
                        poll_cnt_r <= poll_cnt_r + 16'h0001;
                        state_r <= S_PRE_POLL;
                    end
                end
                S_SETUP:
                    if (bus_done)
                        state_r <= S_CONFIRM;
                S_CONFIRM:
                    if (bus_done)
                    begin
                        poll_cnt_r <= 16'h0000;
                        state_r <= S_POLL;
                    end
                S_POLL:
                    if (bus_done)
                        state_r <= S_POLL_WAIT;
                S_POLL_WAIT:
                begin
                    // reads now return status, not array data
                    if (st_ready || status_output_pin_in && !op_config_r && st_ready) // RQ5 RQ6
                    begin
                        status_out <= bus_rdata;
                        clear_fail_out <= bus_rdata[`SR_ERASE_ERR]; // RQ7
                        protection_error_out <= bus_rdata[`SR_PROT_ERR]; // RQ11
                        low_voltage_out <= bus_rdata[`SR_LOW_VPP]; // RQ10
                        sequence_error_out <= bus_rdata[`SR_ERASE_ERR]
                                            & bus_rdata[`SR_PROG_ERR]; // RQ9
                        config_rejected_out <= op_config_r & st_err; // RQ24
                        state_r <= st_err ? S_CLR_STAT : S_FINISH; // RQ7
                    end
                    else if (poll_cnt_r == `POLL_LIMIT)
                    begin
                        // lock bits undefined after abort; user must repeat
                        retry_needed_out <= 1'b1; // RQ12
                        state_r <= S_FINISH;
                    end
                    else
                    begin
                        poll_cnt_r <= poll_cnt_r + 16'h0001;
                        state_r <= S_POLL;
                    end
                end
                S_CLR_STAT:
                    if (bus_done)
                        state_r <= S_FINISH;
                S_FINISH:
                begin
                    done_out <= 1'b1;
                    state_r <= S_IDLE;
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

endmodule

// ---- lockcfg_consts.vh ----
// Purpose: shared constants for the flash lock-clear and status-pin host controller
// Assumes: plain Verilog-2005, included by bare name
// Notes: definitions only
//
// What this block does
// [RQ1] one clear command unlocks all blocks
// [RQ2] master set needs override voltage for clear
// [RQ3] clear refused while busy or suspended
// [RQ4] clear is setup write then confirm write
// [RQ5] reads return status after clear sequence
// [RQ6] completion seen on status pin or ready; the host here decides on the ready bit alone
// [RQ7] host checks erase error, clears status
// [RQ8] stays in read-status until new command
// [RQ9] invalid clear sequence sets both error bits
// [RQ10] lockout voltage sets low-voltage and erase errors
// [RQ11] master set, normal level: protection error
// [RQ12] host repeats clear after aborted operation; this host only raises retry_needed_out
// [RQ13] master bit can never be cleared
// [RQ14] unlocked block erasable at any level
// [RQ15] locked block needs override voltage
// [RQ16] lock changes gated by master bit
// [RQ17] master set needs override voltage only
// [RQ18] only two low code bits; rest zero
// [RQ19] code selects level or pulse modes
// [RQ20] pulse modes pulse low on completion
// [RQ21] host writes config byte then code
// [RQ22] level mode low busy, high ready
// [RQ23] config persists until reconfig or reset
// [RQ24] unsupported config code sets both errors
// [RQ25] host configures only when ready
// [RQ26] wrong confirm is invalid, bits unchanged
// [RQ27] pulse width is a build parameter
`ifndef LOCKCFG_CONSTS_VH
`define LOCKCFG_CONSTS_VH

// command bytes
`define CMD_CLEAR_SETUP    8'h60
`define CMD_CLEAR_CONFIRM  8'hD0
`define CMD_PIN_CONFIG     8'hB8
`define CMD_READ_STATUS    8'h70
`define CMD_CLEAR_STATUS   8'h50
`define CMD_READ_ARRAY     8'hFF

// status bit positions
`define SR_READY           7
`define SR_SUSPEND         6
`define SR_ERASE_ERR       5
`define SR_PROG_ERR        4
`define SR_LOW_VPP         3
`define SR_PROT_ERR        1

// configuration code field
`define CODE_MASK          8'h03
`define CODE_LEVEL         2'h0

// bus timing, in ns and cycles at 50 MHz
`define CLK_PERIOD_NS      20
`define WE_LOW_NS          70
`define WE_HIGH_NS         30
`define OE_ACCESS_NS       150
`define WE_LOW_CYC   ((`WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_HIGH_CYC  ((`WE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OE_ACCESS_CYC ((`OE_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W            4
`define POLL_LIMIT         16'hFFFF

`endif

// ---- bus_cycle_engine.v ----
// Purpose: one write or read cycle on the flash parallel pins
// Assumes: pins synchronous to core_clk_in
// Notes: data pin is split into in, out and output enable
`timescale 1ns/1ps
`include "lockcfg_consts.vh"

module bus_cycle_engine
(
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    input  wire        start_in,
    input  wire        write_in,
    input  wire [7:0]  wdata_in,
    input  wire [7:0]  flash_dq_in,
    output reg  [7:0]  flash_dq_out,
    output reg         flash_dq_oe_out,
    output reg         flash_we_n_out,
    output reg         flash_oe_n_out,
    output reg  [7:0]  rdata_out,
    output reg         done_out
);

    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_LOW   = 2'h1;
    localparam [1:0] S_HIGH  = 2'h2;

    // cycle counts cut to the timer width on purpose
    localparam integer            WE_LOW_I  = `WE_LOW_CYC;
    localparam integer            WE_HIGH_I = `WE_HIGH_CYC;
    localparam integer            OE_ACC_I  = `OE_ACCESS_CYC;
    localparam [`TIMER_W-1:0]     T_WE_LOW  = WE_LOW_I[`TIMER_W-1:0];
    localparam [`TIMER_W-1:0]     T_WE_HIGH = WE_HIGH_I[`TIMER_W-1:0];
    localparam [`TIMER_W-1:0]     T_OE_ACC  = OE_ACC_I[`TIMER_W-1:0];

    reg [1:0]            state_r;
    reg [`TIMER_W-1:0]   timer_r;
    reg                  is_write_r;

    // ========================================
    // strobe sequencing
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r         <= S_IDLE;
            timer_r         <= {`TIMER_W{1'b0}};
            is_write_r      <= 1'b0;
            flash_dq_out    <= 8'h00;
            flash_dq_oe_out <= 1'b0;
            flash_we_n_out  <= 1'b1;
            flash_oe_n_out  <= 1'b1;
            rdata_out       <= 8'h00;
            done_out        <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    if (start_in)
                    begin
                        is_write_r <= write_in;
                        flash_dq_out <= wdata_in;
                        flash_dq_oe_out <= write_in;
                        flash_we_n_out <= ~write_in;
                        flash_oe_n_out <= write_in;
                        timer_r <= write_in ? T_WE_LOW : T_OE_ACC;
                        state_r <= S_LOW;
                    end
                end
                S_LOW:
                begin
                    if (timer_r > 1)
                        timer_r <= timer_r - 1'b1;
                    else
                    begin
                        // device latches data on the rising write strobe
                        flash_we_n_out <= 1'b1;
                        flash_oe_n_out <= 1'b1;
                        if (!is_write_r)
                            rdata_out <= flash_dq_in;
                        timer_r <= T_WE_HIGH;
                        state_r <= S_HIGH;
                    end
                end
                S_HIGH:
                begin
                    if (timer_r > 1)
                        timer_r <= timer_r - 1'b1;
                    else
                    begin
                        flash_dq_oe_out <= 1'b0;
                        done_out <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

endmodule

// ---- lock_clear_host_checker.sv ----
// Purpose: port-level timing and result checks for lock_clear_host
// Assumes: one clock domain, asynchronous active-low reset
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ps
module lock_clear_host_checker
(
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       clear_req_in,
    input wire logic       config_req_in,
    input wire logic       flash_dq_oe_out,
    input wire logic       flash_we_n_out,
    input wire logic       flash_oe_n_out,
    input wire logic       busy_out,
    input wire logic       done_out,
    input wire logic       clear_fail_out,
    input wire logic       protection_error_out,
    input wire logic       low_voltage_out,
    input wire logic       sequence_error_out,
    input wire logic [7:0] flash_dq_out,
    input wire logic [7:0] status_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (!rst_n_in);
// ========================================
// bus cycles
AST_STROBES_EXCL: assert property (flash_we_n_out || flash_oe_n_out)
    else $error("write and read strobes low together");
AST_WRITE_DRIVES: assert property (!flash_we_n_out |-> flash_dq_oe_out)
    else $error("write strobe low with bus released");
AST_READ_RELEASES: assert property (!flash_oe_n_out |-> !flash_dq_oe_out)
    else $error("bus driven during a read");
AST_WE_WIDTH: assert property ($fell(flash_we_n_out) |-> (!flash_we_n_out)[*4])
    else $error("write strobe too short");
AST_DATA_HOLD: assert property ($rose(flash_we_n_out) |-> flash_dq_oe_out)
    else $error("data released at strobe rise");
AST_DATA_STABLE: assert property (
    !flash_we_n_out && !$fell(flash_we_n_out) |-> $stable(flash_dq_out))
    else $error("data moved under strobe");
AST_OE_WIDTH: assert property ($fell(flash_oe_n_out) |-> (!flash_oe_n_out)[*8])
    else $error("read strobe too short");
// ========================================
// request and results
AST_TAKEN: assert property (!busy_out && (clear_req_in || config_req_in) |=> busy_out)
    else $error("request not taken");
AST_DONE_ONE: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
AST_FAIL_BIT: assert property (done_out |=> clear_fail_out == status_out[5])
    else $error("clear fail flag wrong");
AST_PROT_BIT: assert property (done_out |=> protection_error_out == status_out[1])
    else $error("protection flag wrong");
AST_LOWV_BIT: assert property (done_out |=> low_voltage_out == status_out[3])
    else $error("low voltage flag wrong");
AST_SEQ_BIT: assert property (
    done_out |=> sequence_error_out == (status_out[5] && status_out[4]))
    else $error("sequence flag wrong");
CV_CLEAN: cover property (done_out && !status_out[5]);
CV_PROT: cover property (done_out ##1 protection_error_out);
CV_LOWV: cover property (done_out ##1 low_voltage_out);
endmodule
bind lock_clear_host lock_clear_host_checker u_lock_clear_host_checker
(
    .core_clk_in          (core_clk_in),
    .rst_n_in             (rst_n_in),
    .clear_req_in         (clear_req_in),
    .config_req_in        (config_req_in),
    .flash_dq_oe_out      (flash_dq_oe_out),
    .flash_we_n_out       (flash_we_n_out),
    .flash_oe_n_out       (flash_oe_n_out),
    .busy_out             (busy_out),
    .done_out             (done_out),
    .clear_fail_out       (clear_fail_out),
    .protection_error_out (protection_error_out),
    .low_voltage_out      (low_voltage_out),
    .sequence_error_out   (sequence_error_out),
    .flash_dq_out         (flash_dq_out),
    .status_out           (status_out)
);

// ---- flash_dev_model.sv ----
// Purpose: behavioural flash command logic facing lock_clear_host
// Assumes: commands taken on the rising write strobe
// Notes: four lock blocks; busy time and pulse width are parameters
`timescale 1ns/1ps
module flash_dev_model #(
    parameter BUSY_NS  = 400,
    parameter PULSE_NS = 250
) (
    input  wire logic       we_n_in,
    input  wire logic       oe_n_in,
    input  wire logic [7:0] host_dq_in,
    input  wire logic       override_in,
    input  wire logic       program_enable_voltage_low_in,
    output wire logic [7:0] dq_out,
    output wire logic       sts_out
);
logic [7:0] sr_r = 8'h80, code_r = 8'h00, last_r = 8'h00;
logic [3:0] locks_r = 4'h0;
logic       master_r = 1'b0, status_mode_r = 1'b0, pulse_r = 1'b0;
logic       clear_pend_r = 1'b0, config_pend_r = 1'b0;
// bench hook: spoils the next second cycle, as a corrupted write would
logic       spoil_r = 1'b0;
function automatic logic may_alter(input int b);
    return !locks_r[b] || override_in;
endfunction
task automatic set_locks(input logic [3:0] v);
    locks_r = v;
endtask
task automatic set_master();
    if (override_in)
        master_r = 1'b1;
endtask
// ========================================
// command decode; blocking delay models the busy machine
always @(posedge we_n_in)
begin : decode
    logic [7:0] d;
    d = host_dq_in;
    if (clear_pend_r)
    begin
        clear_pend_r = 1'b0;
        if (d != 8'hD0 || spoil_r)
            sr_r[5:4] = 2'h3;
        else if (program_enable_voltage_low_in)
            sr_r = sr_r | 8'h28;
        else if (master_r && !override_in)
            sr_r = sr_r | 8'h22;
        else
        begin
            sr_r[7] = 1'b0;
            #BUSY_NS;
            locks_r = 4'h0;
            sr_r[7] = 1'b1;
        end
        spoil_r = 1'b0;
    end
    else if (config_pend_r)
    begin
        config_pend_r = 1'b0;
        if (d[7:2] != 6'h00 || spoil_r)
            sr_r[5:4] = 2'h3;
        else
            code_r = d;
        spoil_r = 1'b0;
    end
    else
        case (d)
            8'h60:
                if (sr_r[7] && !sr_r[6])
                    clear_pend_r = 1'b1;
                else
                    sr_r[5:4] = 2'h3;
            8'hB8: config_pend_r = 1'b1;
            8'h50: sr_r[5:1] = 5'h00;
            default: ;
        endcase
    if (d != 8'h50)
        status_mode_r = (d != 8'hFF);
end
// released bus shows the inverse of the last byte, not a held value
always @(negedge oe_n_in)
    last_r = status_mode_r ? sr_r : 8'hA5;
assign dq_out = oe_n_in ? ~last_r : (status_mode_r ? sr_r : 8'hA5);
// lock clearing counts as an erase-class completion
always @(posedge sr_r[7])
begin
    pulse_r = code_r[0];
    #PULSE_NS;
    pulse_r = 1'b0;
end
assign sts_out = (code_r[1:0] == 2'h0) ? sr_r[7] : !pulse_r;
endmodule

// ---- tb_lock_clear_host.sv ----
// Purpose: self-checking bench for lock_clear_host
// Assumes: flash model on the far side, 50 MHz clock
// Notes: fixed corner cases first, then seeded random lock and voltage states
`timescale 1ns/1ps
module tb_lock_clear_host;
logic       core_clk_in = 1'b0, rst_n_in = 1'b0, clear_req_in = 1'b0;
logic       config_req_in = 1'b0, override = 1'b0, program_enable_voltage_low = 1'b0, master = 1'b0;
logic [1:0] pin_mode_code_bits_in = 2'h0;
wire  [7:0] flash_dq_in, flash_dq_out, dev_dq, status_out;
wire        flash_dq_oe_out, flash_we_n_out, flash_oe_n_out, status_output_pin_in;
wire        busy_out, done_out, clear_fail_out, protection_error_out, low_voltage_out;
wire        sequence_error_out, config_rejected_out, retry_needed_out;
int         err_count = 0, num_checks = 0, seed = 74;
assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : dev_dq;
lock_clear_host u_lock_clear_host (.*);
flash_dev_model u_flash_dev_model (.we_n_in(flash_we_n_out), .oe_n_in(flash_oe_n_out),
    .host_dq_in(flash_dq_in), .override_in(override), .program_enable_voltage_low_in(program_enable_voltage_low),
    .dq_out(dev_dq), .sts_out(status_output_pin_in));
initial forever #10 core_clk_in = ~core_clk_in;
// ========================================
// helpers
function automatic logic [2:0] exp_flags(input logic m, input logic ov, input logic vl);
    if (vl)
        return 3'b101;
    if (m && !ov)
        return 3'b110;
    return 3'b000;
endfunction
task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        err_count++;
        $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
endtask
task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
task automatic run(input logic clr, input logic [1:0] code);
    int n;
    n = 0;
    clear_req_in <= clr;
    config_req_in <= !clr;
    pin_mode_code_bits_in <= code;
    @(posedge core_clk_in);
    clear_req_in <= 1'b0;
    config_req_in <= 1'b0;
    while (done_out !== 1'b1 && n < 5000)
    begin
        @(posedge core_clk_in);
        n++;
    end
    if (n == 5000)
    begin
        err_count++;
        summarize();
    end
    @(posedge core_clk_in);
endtask
// ========================================
// main sequence
initial
begin
    logic [3:0] lk;
    logic [2:0] ef;
    logic [1:0] cd;
    int         i;
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    for (i = 0; i < 6; i++)
    begin
        cd = (i < 4) ? i[1:0] : 2'($random(seed));
        run(1'b0, cd);
        check(u_flash_dev_model.code_r, 8'(cd));
        check(8'(config_rejected_out), 8'h00);
    end
    for (i = 0; i < 16; i++)
    begin
        lk = (i < 4) ? 4'hF : 4'($random(seed));
        override <= (i == 3) || (i > 3 && 1'($random(seed)));
        program_enable_voltage_low <= (i == 1) || (i > 3 && ($random(seed) % 4 == 0));
        @(posedge core_clk_in);
        u_flash_dev_model.set_locks(lk);
        check(8'(u_flash_dev_model.may_alter(0)), 8'(!lk[0] || override));
        if (i == 2 || i == 3 || i == 9)
        begin
            u_flash_dev_model.set_master();
            master = master | override;
        end
        ef = exp_flags(master, override, program_enable_voltage_low);
        run(1'b1, 2'h0);
        check(8'({clear_fail_out, protection_error_out, low_voltage_out}), 8'(ef));
        check(8'(u_flash_dev_model.locks_r), (ef == 3'h0) ? 8'h00 : 8'(lk));
        check(8'(u_flash_dev_model.master_r), 8'(master));
        check(u_flash_dev_model.sr_r & 8'h3A, 8'h00);
        check(8'({status_out[7], sequence_error_out, retry_needed_out}), 8'h04);
    end
    // spoiled confirm and spoiled code: both error bits, nothing changed
    u_flash_dev_model.set_locks(4'hA);
    u_flash_dev_model.spoil_r = 1'b1;
    run(1'b1, 2'h0);
    check(8'({clear_fail_out, sequence_error_out, protection_error_out}), 8'h06);
    check(8'(u_flash_dev_model.locks_r), 8'h0A);
    u_flash_dev_model.spoil_r = 1'b1;
    run(1'b0, 2'h1);
    check(8'({config_rejected_out, sequence_error_out}), 8'h03);
    check(u_flash_dev_model.code_r, 8'(cd));
    // reset lands inside the idle-check read, never under a write strobe
    clear_req_in <= 1'b1;
    repeat (12) @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    clear_req_in <= 1'b0;
    @(posedge core_clk_in);
    check(8'({flash_we_n_out, flash_oe_n_out, flash_dq_oe_out, busy_out, done_out}), 8'h18);
    rst_n_in <= 1'b1;
    override <= 1'b1;
    program_enable_voltage_low <= 1'b0;
    repeat (40) @(posedge core_clk_in);
    u_flash_dev_model.set_locks(4'hF);
    run(1'b1, 2'h0);
    check(8'(u_flash_dev_model.locks_r), 8'h00);
    summarize();
end
endmodule
